// File: src/cccr_config_bank.sv
// three 16-bit configuration words with decoded field outputs,
// the startup mode sequencer and the dac refresh timer
// assumes load strobe and word-seen pulse come from clk_sys logic
`timescale 1ns/1ps

module cccr_config_bank
	import cccr_pkg::*;
#(
	parameter int unsigned MS_DIV       = MS_CYCLES,
	parameter int unsigned REFRESH_DIV  = REFRESH_CYCLES,
	parameter logic [15:0] STARTUP_INIT = STARTUP_RST
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        cfg_load,
	input  wire logic [1:0]  cfg_sel,
	input  wire logic [15:0] cfg_data,
	input  wire logic        ctrl_word_seen,
	output logic [15:0]      analog_front_config,
	output logic [15:0]      system_option_config,
	output logic [15:0]      startup_mode_config,
	output logic [4:0]       gain_code,
	output logic [11:0]      gain_value,
	output logic             input_polarity_swap,
	output logic             coarse_offset_direction,
	output logic [3:0]       coarse_offset_magnitude,
	output logic [1:0]       mirror_ratio_select,
	output logic             offset_dac_polarity,
	output logic             offset_tempco_dac_polarity,
	output logic             fault_detect_enable,
	output logic [1:0]       dac_refresh_select,
	output logic             line_pullup_enable,
	output logic [1:0]       read_response_delay,
	output logic [3:0]       read_delay_bytes,
	output logic             excitation_select,
	output logic [3:0]       control_word_wait,
	output logic [2:0]       control_word_repeats,
	output logic             digital_mode,
	output logic             analog_mode,
	output logic             dac_refresh_tick
);

	// gain steps in volts per volt, indexed by the five-bit code
	localparam logic [11:0] GAIN_TAB [32] = '{
		12'h006, 12'h007, 12'h009, 12'h00b, 12'h00c, 12'h00e, 12'h012,
		12'h016, 12'h01c, 12'h024, 12'h02c, 12'h034, 12'h040, 12'h050,
		12'h060, 12'h070, 12'h090, 12'h0b0, 12'h0d0, 12'h100, 12'h120,
		12'h160, 12'h1a0, 12'h200, 12'h240, 12'h2c0, 12'h340, 12'h400,
		12'h480, 12'h580, 12'h680, 12'h800
	};

	// milliseconds waited per control-word repetition
	function automatic logic [4:0] wait_ms_of(input logic [3:0] c);
		logic [4:0] m;
		m = 5'h1e;
		case (c)
			4'h0: m = 5'd1;
			4'h1: m = 5'd2;
			4'h2: m = 5'd3;
			4'h3: m = 5'd4;
			4'h4: m = 5'd5;
			4'h5: m = 5'd8;
			4'h6: m = 5'd10;
			4'h7: m = 5'd15;
			4'h8: m = 5'd20;
			4'h9: m = 5'd25;
			default: m = 5'd30;
		endcase
		return m;
	endfunction : wait_ms_of

	typedef struct packed {
		logic [15:0] front;
		logic [15:0] option;
		logic [15:0] startup;
		logic [11:0] gain;
		logic [3:0]  rd_bytes;
		logic [5:0]  ref_cnt;
		logic        refresh;
		cccr_state_t st;
		logic [2:0]  rep_cnt;
		logic [4:0]  ms_cnt;
	} cccr_regs_t;

	cccr_regs_t q;
	cccr_regs_t d;
	logic       ms_tick;
	logic       base_tick;
	logic [2:0] reps_req;
	logic [4:0] wait_ms;
	logic [5:0] ref_mult;

	// millisecond base for the startup window
	cccr_tick_div #(.DIV(MS_DIV)) u_ms_div (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.tick    (ms_tick)
	);

	// 4.096 ms base; longer refresh intervals are multiples of it
	cccr_tick_div #(.DIV(REFRESH_DIV)) u_ref_div (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.tick    (base_tick)
	);

	// decode of the live startup and refresh settings
	always_comb begin
		reps_req = q.startup[REPS_LSB +: 3];
		if (reps_req == 3'h0) begin
			reps_req = 3'h1;
		end
		wait_ms = wait_ms_of(q.startup[WAIT_LSB +: 4]);
		case (q.option[REFRESH_LSB +: 2])
			2'h0:    ref_mult = 6'h01;
			2'h1:    ref_mult = 6'h04;
			2'h2:    ref_mult = 6'h10;
			default: ref_mult = 6'h20;
		endcase
	end

	// next state: word loads, startup sequencer, refresh timer
	always_comb begin
		d = q;
		d.refresh = 1'b0;
		// a word is replaced whole; reserved bits kept as written
		if (cfg_load) begin
			case (cfg_sel)
				SEL_FRONT: begin
					d.front = cfg_data;
					d.gain = GAIN_TAB[cfg_data[GAIN_LSB +: 5]];
				end
				SEL_OPTION: begin
					d.option = cfg_data;
					// one-hot byte count; codes 0 to 3 give 1, 2, 4 and 8 byte times
					d.rd_bytes = 4'h1 << cfg_data[RDDLY_LSB +: 2];
				end
				SEL_STARTUP: d.startup = cfg_data;
				default:     d.front = q.front; // select 3 is ignored
			endcase
		end
		case (q.st)
			ST_BOOT: begin
				d.rep_cnt = 3'h0;
				d.ms_cnt = 5'h00;
				if (q.startup[REPS_LSB +: 3] == REPS_DIRECT) begin
					d.st = ST_DIG;
				end else begin
					d.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// a word arriving with the ms tick wins; window restarts
				if (ctrl_word_seen) begin
					d.ms_cnt = 5'h00;
					if ({1'b0, q.rep_cnt} + 4'h1 >= {1'b0, reps_req}) begin
						d.st = ST_DIG;
					end else begin
						d.rep_cnt = q.rep_cnt + 3'h1;
					end
				end else if (ms_tick) begin
					if (q.ms_cnt + 5'h01 >= wait_ms) begin
						d.st = ST_ANA;
					end else begin
						d.ms_cnt = q.ms_cnt + 5'h01;
					end
				end
			end
			ST_DIG:  d.st = ST_DIG;
			ST_ANA:  d.st = ST_ANA;
			default: d.st = ST_BOOT;
		endcase
		// refresh only counts in fixed analog mode
		if (q.st != ST_ANA) begin
			d.ref_cnt = 6'h00;
		end else if (base_tick) begin
			if (q.ref_cnt + 6'h01 >= ref_mult) begin
				d.ref_cnt = 6'h00;
				d.refresh = 1'b1;
			end else begin
				d.ref_cnt = q.ref_cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			q.front   <= FRONT_RST;
			q.option  <= OPTION_RST;
			q.startup <= STARTUP_INIT;
			q.gain    <= 12'h006;
			q.rd_bytes <= 4'h1 << OPTION_RST[RDDLY_LSB +: 2];
			q.ref_cnt <= 6'h00;
			q.refresh <= 1'b0;
			q.st      <= ST_BOOT;
			q.rep_cnt <= 3'h0;
			q.ms_cnt  <= 5'h00;
		end else begin
			q <= d;
		end
	end

	// field outputs are slices of the word flops, except gain_value and read_delay_bytes, which have decode flops of their own
	assign analog_front_config  = q.front;
	assign system_option_config = q.option;
	assign startup_mode_config  = q.startup;
	assign gain_code               = q.front[GAIN_LSB +: 5];
	assign gain_value              = q.gain;
	assign input_polarity_swap     = q.front[SWAP_BIT];
	assign coarse_offset_direction = q.front[OFSDIR_BIT];
	assign coarse_offset_magnitude = q.front[OFSMAG_LSB +: 4];
	assign mirror_ratio_select     = q.front[MIRROR_LSB +: 2];
	assign offset_dac_polarity     = q.front[ODAC_BIT];
	assign offset_tempco_dac_polarity = q.front[OTC_BIT];
	assign fault_detect_enable     = q.option[FAULT_BIT];
	assign dac_refresh_select      = q.option[REFRESH_LSB +: 2];
	assign line_pullup_enable      = q.option[PULLUP_BIT];
	assign read_response_delay     = q.option[RDDLY_LSB +: 2];
	assign read_delay_bytes        = q.rd_bytes;
	assign excitation_select       = q.option[EXC_BIT];
	assign control_word_wait       = q.startup[WAIT_LSB +: 4];
	assign control_word_repeats    = q.startup[REPS_LSB +: 3];
	// one-hot state, so each mode flag is a state flop itself
	assign digital_mode            = q.st[2];
	assign analog_mode             = q.st[3];
	assign dac_refresh_tick        = q.refresh;

	sequence s_front_load;
		cfg_load && cfg_sel == SEL_FRONT;
	endsequence

	sequence s_option_load;
		cfg_load && cfg_sel == SEL_OPTION;
	endsequence

	property p_gain;
		@(posedge clk_sys) disable iff (!rstn)
		s_front_load ##0 cfg_data[GAIN_LSB +: 5] == 5'h1f
			|=> gain_value == 12'h800;
	endproperty
	a_gain: assert property (p_gain)
		else $error("top gain code did not give 2048");

	property p_swap;
		@(posedge clk_sys) disable iff (!rstn)
		s_front_load |=> input_polarity_swap == $past(cfg_data[SWAP_BIT]);
	endproperty
	a_swap: assert property (p_swap)
		else $error("polarity swap does not follow bit 10");

	property p_offset;
		@(posedge clk_sys) disable iff (!rstn)
		s_front_load |=>
			coarse_offset_magnitude == $past(cfg_data[OFSMAG_LSB +: 4])
			&& coarse_offset_direction == $past(cfg_data[OFSDIR_BIT]);
	endproperty
	a_offset: assert property (p_offset)
		else $error("coarse offset fields not loaded");

	property p_pullup;
		@(posedge clk_sys) disable iff (!rstn)
		s_option_load |=> line_pullup_enable == $past(cfg_data[PULLUP_BIT])
			&& fault_detect_enable == $past(cfg_data[FAULT_BIT]);
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("pullup or fault enable not loaded");

	property p_hold;
		@(posedge clk_sys) disable iff (!rstn)
		!cfg_load |=> $stable(analog_front_config)
			&& $stable(system_option_config) && $stable(gain_value);
	endproperty
	a_hold: assert property (p_hold)
		else $error("configuration changed without a load");

	property p_direct;
		@(posedge clk_sys) disable iff (!rstn)
		q.st == ST_BOOT && control_word_repeats == REPS_DIRECT
			|=> digital_mode;
	endproperty
	a_direct: assert property (p_direct)
		else $error("repeat code 7 did not enter digital mode");

	property p_window;
		@(posedge clk_sys) disable iff (!rstn)
		q.st == ST_WAIT && ms_tick && !ctrl_word_seen
			&& q.ms_cnt + 5'h01 >= wait_ms |=> analog_mode;
	endproperty
	a_window: assert property (p_window)
		else $error("wait window expiry did not enter analog mode");

	property p_refresh_mode;
		@(posedge clk_sys) disable iff (!rstn)
		dac_refresh_tick |-> $past(analog_mode) && $past(base_tick);
	endproperty
	a_refresh_mode: assert property (p_refresh_mode)
		else $error("refresh tick outside analog mode");

	property p_delay;
		@(posedge clk_sys) disable iff (!rstn)
		s_option_load ##0 cfg_data[RDDLY_LSB +: 2] == 2'h3
			|=> read_delay_bytes == 4'h8;
	endproperty
	a_delay: assert property (p_delay)
		else $error("read delay code 3 is not 8 byte times");

endmodule : cccr_config_bank

// File: inc/cccr_pkg.sv
// constants for the conditioner configuration word bank
// assumes a single 40 MHz clock and a same-clock load strobe
package cccr_pkg;

	// clock and timing
	localparam int unsigned CLK_PERIOD_NS   = 25;
	localparam int unsigned MS_PERIOD_NS    = 1000000;
	localparam int unsigned MS_CYCLES       = MS_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned REFRESH_BASE_NS = 4096000;
	localparam int unsigned REFRESH_CYCLES  =
		REFRESH_BASE_NS / CLK_PERIOD_NS;

	// word selects on the load port
	localparam logic [1:0] SEL_FRONT   = 2'h0;
	localparam logic [1:0] SEL_OPTION  = 2'h1;
	localparam logic [1:0] SEL_STARTUP = 2'h2;

	// reset values; startup word matches the shipped direct-digital setting
	localparam logic [15:0] FRONT_RST   = 16'h0000;
	localparam logic [15:0] OPTION_RST  = 16'h0000;
	localparam logic [15:0] STARTUP_RST = 16'h007f;

	// analog front word fields
	localparam int unsigned GAIN_LSB   = 11;
	localparam int unsigned SWAP_BIT   = 10;
	localparam int unsigned OFSDIR_BIT = 9;
	localparam int unsigned OFSMAG_LSB = 5;
	localparam int unsigned MIRROR_LSB = 3;
	localparam int unsigned ODAC_BIT   = 1;
	localparam int unsigned OTC_BIT    = 0;

	// system option word fields
	localparam int unsigned FAULT_BIT   = 6;
	localparam int unsigned REFRESH_LSB = 4;
	localparam int unsigned PULLUP_BIT  = 3;
	localparam int unsigned RDDLY_LSB   = 1;
	localparam int unsigned EXC_BIT     = 0;

	// startup word fields
	localparam int unsigned WAIT_LSB = 3;
	localparam int unsigned REPS_LSB = 0;
	localparam logic [2:0]  REPS_DIRECT = 3'h7;

	// startup sequencer states
	typedef enum logic [3:0] {
		ST_BOOT = 4'h1,
		ST_WAIT = 4'h2,
		ST_DIG  = 4'h4,
		ST_ANA  = 4'h8
	} cccr_state_t;

endpackage : cccr_pkg

// File: src/cccr_tick_div.sv
// free-running divider giving a one-cycle enable every DIV clocks
// assumes DIV is at least 2 and below 2**18
`timescale 1ns/1ps
module cccr_tick_div #(
	parameter int unsigned DIV = 40000
) (
	input  wire logic clk_sys,
	input  wire logic rstn,
	output logic      tick
);

	localparam logic [17:0] LAST = 18'(DIV - 1);

	typedef struct packed {
		logic [17:0] cnt;
		logic        tick;
	} cccr_div_t;

	cccr_div_t q;
	cccr_div_t d;

	// wrap at the last count and fire for exactly one cycle
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.cnt == LAST) begin
			d.cnt = 18'h00000;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 18'h00001;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;

	property p_tick_single;
		@(posedge clk_sys) disable iff (!rstn)
		q.tick |=> !q.tick;
	endproperty
	a_tick_single: assert property (p_tick_single)
		else $error("divider tick lasted more than one cycle");

endmodule : cccr_tick_div

// File: tb/testbench.sv
// self-checking bench for the conditioner configuration word bank
// assumes cccr_pkg is compiled first; drives the load port directly
`timescale 1ns/1ps
module testbench;
	import cccr_pkg::*;

	logic        clk_sys;
	logic        rstn;
	logic        cfg_load;
	logic [1:0]  cfg_sel;
	logic [15:0] cfg_data;
	logic        ctrl_word_seen;
	logic [15:0] analog_front_config;
	logic [15:0] system_option_config;
	logic [15:0] startup_mode_config;
	logic [4:0]  gain_code;
	logic [11:0] gain_value;
	logic        input_polarity_swap;
	logic        coarse_offset_direction;
	logic [3:0]  coarse_offset_magnitude;
	logic [1:0]  mirror_ratio_select;
	logic        offset_dac_polarity;
	logic        offset_tempco_dac_polarity;
	logic        fault_detect_enable;
	logic [1:0]  dac_refresh_select;
	logic        line_pullup_enable;
	logic [1:0]  read_response_delay;
	logic [3:0]  read_delay_bytes;
	logic        excitation_select;
	logic [3:0]  control_word_wait;
	logic [2:0]  control_word_repeats;
	logic        digital_mode;
	logic        analog_mode;
	logic        dac_refresh_tick;
	int          fails;
	int          checks;
	logic        dig2;
	logic        ana2;
	logic        tick2;

	// dividers shrunk so a millisecond is MS_TB clocks
	localparam int MS_TB    = 20;
	localparam int REF_BASE = 40;
	localparam int WIN      = 3 * MS_TB; // wait code 2 is 3 ms

	// gain steps for codes 0..31
	localparam logic [11:0] GTAB [32] = '{
		12'd6, 12'd7, 12'd9, 12'd11, 12'd12, 12'd14, 12'd18, 12'd22,
		12'd28, 12'd36, 12'd44, 12'd52, 12'd64, 12'd80, 12'd96, 12'd112,
		12'd144, 12'd176, 12'd208, 12'd256, 12'd288, 12'd352, 12'd416,
		12'd512, 12'd576, 12'd704, 12'd832, 12'd1024, 12'd1152,
		12'd1408, 12'd1664, 12'd2048};

	// small dividers keep the run short
	cccr_config_bank #(.MS_DIV(MS_TB), .REFRESH_DIV(REF_BASE)) i_dut (
		.clk_sys                    (clk_sys),
		.rstn                       (rstn),
		.cfg_load                   (cfg_load),
		.cfg_sel                    (cfg_sel),
		.cfg_data                   (cfg_data),
		.ctrl_word_seen             (ctrl_word_seen),
		.analog_front_config        (analog_front_config),
		.system_option_config       (system_option_config),
		.startup_mode_config        (startup_mode_config),
		.gain_code                  (gain_code),
		.gain_value                 (gain_value),
		.input_polarity_swap        (input_polarity_swap),
		.coarse_offset_direction    (coarse_offset_direction),
		.coarse_offset_magnitude    (coarse_offset_magnitude),
		.mirror_ratio_select        (mirror_ratio_select),
		.offset_dac_polarity        (offset_dac_polarity),
		.offset_tempco_dac_polarity (offset_tempco_dac_polarity),
		.fault_detect_enable        (fault_detect_enable),
		.dac_refresh_select         (dac_refresh_select),
		.line_pullup_enable         (line_pullup_enable),
		.read_response_delay        (read_response_delay),
		.read_delay_bytes           (read_delay_bytes),
		.excitation_select          (excitation_select),
		.control_word_wait          (control_word_wait),
		.control_word_repeats       (control_word_repeats),
		.digital_mode               (digital_mode),
		.analog_mode                (analog_mode),
		.dac_refresh_tick           (dac_refresh_tick)
	);

	// second bank boots into the wait window: 3 ms, two control words
	cccr_config_bank #(
		.MS_DIV       (MS_TB),
		.REFRESH_DIV  (REF_BASE),
		.STARTUP_INIT (16'h0012)
	) i_dut_wait (
		.clk_sys                    (clk_sys),
		.rstn                       (rstn),
		.cfg_load                   (cfg_load),
		.cfg_sel                    (cfg_sel),
		.cfg_data                   (cfg_data),
		.ctrl_word_seen             (ctrl_word_seen),
		.analog_front_config        (),
		.system_option_config       (),
		.startup_mode_config        (),
		.gain_code                  (),
		.gain_value                 (),
		.input_polarity_swap        (),
		.coarse_offset_direction    (),
		.coarse_offset_magnitude    (),
		.mirror_ratio_select        (),
		.offset_dac_polarity        (),
		.offset_tempco_dac_polarity (),
		.fault_detect_enable        (),
		.dac_refresh_select         (),
		.line_pullup_enable         (),
		.read_response_delay        (),
		.read_delay_bytes           (),
		.excitation_select          (),
		.control_word_wait          (),
		.control_word_repeats       (),
		.digital_mode               (dig2),
		.analog_mode                (ana2),
		.dac_refresh_tick           (tick2)
	);

	// 25 ns clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask : chk

	// one-cycle strobe; outputs settle on the taking edge and are read 1 ns after it
	task automatic load(input logic [1:0] sel, input logic [15:0] w);
		@(posedge clk_sys);
		cfg_load <= 1'b1;
		cfg_sel  <= sel;
		cfg_data <= w;
		@(posedge clk_sys);
		cfg_load <= 1'b0;
		#1;
	endtask : load

	task automatic front(input logic [15:0] w);
		load(SEL_FRONT, w);
		chk(analog_front_config, w);
		chk(16'(input_polarity_swap), 16'(w[10]));
		chk(16'(coarse_offset_direction), 16'(w[9]));
		chk(16'(coarse_offset_magnitude), 16'(w[8:5]));
		chk(16'(mirror_ratio_select), 16'(w[4:3]));
		chk(16'(offset_dac_polarity), 16'(w[1]));
		chk(16'(offset_tempco_dac_polarity), 16'(w[0]));
	endtask : front

	task automatic modes(input logic dig);
		chk(16'(digital_mode), 16'(dig));
		chk(16'(analog_mode), 16'h0000);
		chk(16'(dac_refresh_tick), 16'h0000);
	endtask : modes

	// cycles between two refresh pulses of the waiting bank
	task automatic ref_gap(input int exp);
		int n;
		n = 0;
		while (tick2 !== 1'b1 && n < 2000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (tick2 !== 1'b1 && n < 2000);
		chk(16'(n), 16'(exp));
	endtask : ref_gap

	task automatic end_sim;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	// watchdog well beyond the expected few hundred cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		end_sim;
	end

	initial begin
		logic [15:0] w;
		fails          = 0;
		checks         = 0;
		rstn           = 1'b0;
		cfg_load       = 1'b0;
		cfg_sel        = 2'h0;
		cfg_data       = 16'h0000;
		ctrl_word_seen = 1'b0;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk(analog_front_config, FRONT_RST);
		chk(system_option_config, OPTION_RST);
		chk(startup_mode_config, STARTUP_RST);
		chk(16'(gain_value), 16'h0006);
		modes(1'b1);
		chk(16'(dig2), 16'h0000);
		chk(16'(ana2), 16'h0000);
		// window of 3 ms, give or take the boot cycle and tick phase
		repeat (WIN - 7) @(posedge clk_sys);
		#1;
		chk(16'(ana2), 16'h0000);
		repeat (10) @(posedge clk_sys);
		#1;
		chk(16'(ana2), 16'h0001);
		chk(16'(dig2), 16'h0000);
		// refresh codes 0 and 1 give one and four base intervals
		ref_gap(REF_BASE);
		load(SEL_OPTION, 16'h0010);
		ref_gap(4 * REF_BASE);
		$display("test reset done");

		// every gain code in turn
		for (int i = 0; i < 32; i++) begin
			load(SEL_FRONT, {5'(i), 11'h000});
			chk(16'(gain_code), 16'(i));
			chk(16'(gain_value), 16'(GTAB[i]));
		end
		$display("test gain done");

		front(16'h06ab);
		front(16'hf950);
		front(16'h0018);
		front(16'h01e0);
		// a while without loads leaves fields alone
		repeat (20) @(posedge clk_sys);
		#1;
		chk(analog_front_config, 16'h01e0);
		chk(16'(coarse_offset_magnitude), 16'h000f);
		$display("test front done");

		// all refresh and delay codes, both levels of each flag
		for (int i = 0; i < 4; i++) begin
			w = {9'h000, 1'(i), 2'(i), ~1'(i), 2'(i), 1'(i >> 1)};
			load(SEL_OPTION, w);
			chk(system_option_config, w);
			chk(16'(fault_detect_enable), 16'(w[6]));
			chk(16'(dac_refresh_select), 16'(i));
			chk(16'(line_pullup_enable), 16'(w[3]));
			chk(16'(read_response_delay), 16'(i));
			chk(16'(read_delay_bytes), 16'h0001 << i);
			chk(16'(excitation_select), 16'(w[0]));
		end
		$display("test option done");

		load(SEL_STARTUP, 16'h0012);
		chk(16'(control_word_wait), 16'h0002);
		chk(16'(control_word_repeats), 16'h0002);
		load(SEL_STARTUP, 16'h0057);
		chk(16'(control_word_wait), 16'h000a);
		chk(16'(control_word_repeats), 16'h0007);
		// control words after startup has ended change nothing
		repeat (3) begin
			@(posedge clk_sys);
			ctrl_word_seen <= 1'b1;
			@(posedge clk_sys);
			ctrl_word_seen <= 1'b0;
		end
		repeat (60) @(posedge clk_sys);
		#1;
		modes(1'b1);
		$display("test startup done");

		// unused select leaves all three words as they were
		load(2'h3, 16'hffff);
		chk(analog_front_config, 16'h01e0);
		chk(system_option_config, w);
		chk(startup_mode_config, 16'h0057);
		$display("test select done");

		// second reset in mid-run restores the words
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(analog_front_config, FRONT_RST);
		chk(startup_mode_config, STARTUP_RST);
		modes(1'b0);
		chk(16'(ana2), 16'h0000);
		@(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		modes(1'b1);
		// repeat code 2: the first word alone does not finish startup
		repeat (2) begin
			chk(16'(dig2), 16'h0000);
			@(posedge clk_sys);
			ctrl_word_seen <= 1'b1;
			@(posedge clk_sys);
			ctrl_word_seen <= 1'b0;
			#1;
		end
		chk(16'(dig2), 16'h0001);
		chk(16'(ana2), 16'h0000);
		$display("test rereset done");
		end_sim;
	end

endmodule : testbench
